/* File: pkg/ssos_params.svh */
`ifndef SSOS_PARAMS_SVH
`define SSOS_PARAMS_SVH

// Clock rate and the one-second time base.
`define SSOS_CLK_HZ 40000000
`define SSOS_SEC_S 1

// Characters on the serial link.
`define SSOS_CH_TAB 8'h09
`define SSOS_CH_LF 8'h0a
`define SSOS_CH_CR 8'h0d
`define SSOS_CH_EXCL 8'h21
`define SSOS_CH_HASH 8'h23
`define SSOS_CH_PCT 8'h25
`define SSOS_CH_STAR 8'h2a
`define SSOS_CH_SLASH 8'h2f
`define SSOS_CH_ZERO 8'h30
`define SSOS_CH_HEXA 8'h37
`define SSOS_CH_SEMI 8'h3b
`define SSOS_CH_P 8'h50

// Field lengths in characters, last index of each.
`define SSOS_KEY_LAST 4'ha
`define SSOS_ID_LAST 4'h3
`define SSOS_NAME_LAST 4'h1
`define SSOS_VAL_LAST 4'h7

// Register byte addresses.
`define SSOS_REG_CTRL 8'h00
`define SSOS_REG_PERIOD 8'h04
`define SSOS_REG_ENABLE 8'h08
`define SSOS_REG_IDENT 8'h0c
`define SSOS_REG_STATUS 8'h10

// Control field positions and reset values.
`define SSOS_CTRL_LABEL 0
`define SSOS_CTRL_TMO_LSB 1
`define SSOS_CTRL_TMO_MSB 3
`define SSOS_CTRL_RUN 4
`define SSOS_CTRL_RST 5'h07
`define SSOS_PERIOD_RST 16'h000a
`define SSOS_ENABLE_RST 8'hff
`define SSOS_IDENT_RST 32'h0001_0001

// Inactivity timeouts in seconds, selected by the timeout code.
`define SSOS_TMO_10S 16'h000a
`define SSOS_TMO_20S 16'h0014
`define SSOS_TMO_30S 16'h001e
`define SSOS_TMO_1M 16'h003c
`define SSOS_TMO_2M 16'h0078
`define SSOS_TMO_5M 16'h012c
`define SSOS_TMO_10M 16'h0258
`define SSOS_TMO_NEVER 3'h7
`define SSOS_REVERT_S 16'h003c

// Access keys.
`define SSOS_KEY_LOW 16'h0001
`define SSOS_KEY_HIGH 16'h03e8

`endif

/* File: pkg/ssos_pkg.sv */
package ssos_pkg;

  typedef enum logic [2:0] {
    SSOS_OP_OK = 3'h0,
    SSOS_OP_ERR = 3'h1,
    SSOS_OP_SAMPLE = 3'h2,
    SSOS_OP_START = 3'h3,
    SSOS_OP_STOP = 3'h4,
    SSOS_OP_PASSKEY = 3'h5,
    SSOS_OP_RESET = 3'h6
  } ssos_op_t;

  typedef struct packed {
    ssos_op_t op;
    logic [15:0] value;
  } ssos_cmd_t;

  typedef enum logic [1:0] {
    SSOS_ACC_DEF = 2'h0,
    SSOS_ACC_LOW = 2'h1,
    SSOS_ACC_HIGH = 2'h2
  } ssos_acc_t;

  typedef enum logic [3:0] {
    SSOS_M_IDLE = 4'h0,
    SSOS_M_KEY = 4'h1,
    SSOS_M_PROD = 4'h2,
    SSOS_M_SER = 4'h3,
    SSOS_M_SCAN = 4'h4,
    SSOS_M_NAME = 4'h5,
    SSOS_M_VAL = 4'h6,
    SSOS_M_TAB = 4'h7,
    SSOS_M_CR = 4'h8,
    SSOS_M_LF = 4'h9
  } ssos_mst_t;

endpackage

/* File: hw/ssos_sec_timer.sv */
`timescale 1ns/1ps
`default_nettype none
// Down counter in whole seconds; a load restarts it and wins over the tick.
module ssos_sec_timer #(
  parameter int W = 16
) (
  // Clock and reset
  input wire logic clk_sys_in,
  input wire logic reset_in,
  // Control
  input wire logic tick_in,
  input wire logic load_in,
  input wire logic stop_in,
  input wire logic [W-1:0] value_in,
  // Status
  output logic expire_out,
  output logic active_out
);

  logic [W-1:0] cnt;

  // A zero load counts as one second so the timer can never hang.
  always_ff @(posedge clk_sys_in or posedge reset_in) begin
    if (reset_in) begin
      cnt <= '0;
      active_out <= 1'b0;
      expire_out <= 1'b0;
    end else begin
      expire_out <= 1'b0;
      if (stop_in) begin
        active_out <= 1'b0;
      end else if (load_in) begin
        cnt <= (value_in == '0) ? {{(W-1){1'b0}}, 1'b1} : value_in;
        active_out <= 1'b1;
      end else if (tick_in && active_out) begin
        if (cnt == {{(W-1){1'b0}}, 1'b1}) begin
          expire_out <= 1'b1;
          active_out <= 1'b0;
        end else begin
          cnt <= cnt - {{(W-1){1'b0}}, 1'b1};
        end
      end
    end
  end

endmodule
`default_nettype wire

/* File: hw/ssos_top.sv */
// Strobed register access and the register addresses were decided locally.
`timescale 1ns/1ps
`default_nettype none
`include "ssos_params.svh"
// Behaviour
// RULE1: Sample on command or interval timer expiry.
// RULE2: Only enabled parameters appear in string.
// RULE3: Label on: MEASUREMENT, product, serial first.
// RULE4: Label off: no keyword, no names.
// RULE5: Every field followed by a tab.
// RULE6: String ends with carriage return, line feed.
// RULE7: Comment lines dropped without any answer.
// RULE8: Interface asleep after reset unless never-sleep.
// RULE9: Any received character wakes the interface.
// RULE10: Sleep after selected input inactivity timeout.
// RULE11: Send percent sign on going to sleep. Code: only on inactivity timeout, not on the reset command.
// RULE12: Send exclamation mark after waking.
// RULE13: Never-sleep keeps interface permanently awake.
// RULE14: Indicators are bare, no line ending.
// RULE15: Key change by set command, acknowledged.
// RULE16: Hash or asterisk answer, then line ending.
// RULE17: Host ends lines with CRLF; case free.
// RULE18: Access level reverts after inactivity.
// RULE19: Interval timer reloads period after expiry.
module ssos_top #(
  parameter int N_PARAMS = 8,
  parameter int SEC_CYCLES = `SSOS_CLK_HZ * `SSOS_SEC_S
) (
  // Clock and reset
  input wire logic clk_sys_in,
  input wire logic reset_in,
  // Register port
  input wire logic [7:0] addr_in,
  input wire logic [31:0] wdata_in,
  input wire logic wr_in,
  input wire logic rd_in,
  output logic [31:0] rdata_out,
  // Serial characters in and out
  input wire logic rx_valid_in,
  input wire logic [7:0] rx_data_in,
  output logic tx_valid_out,
  output logic [7:0] tx_data_out,
  input wire logic tx_ready_in,
  // Command parser link
  output logic line_valid_out,
  output logic [7:0] line_data_out,
  input wire logic cmd_valid_in,
  input wire ssos_pkg::ssos_cmd_t cmd_in,
  // Measurement link
  output logic sample_start_out,
  input wire logic [N_PARAMS-1:0][31:0] param_value_in
);

  localparam int PW = $clog2(N_PARAMS + 1);

  logic [4:0] ctrl;
  logic [15:0] period;
  logic [N_PARAMS-1:0] enable;
  logic [31:0] ident;
  logic awake, ind_pend, sample_pend, at_line_start, in_comment;
  logic [7:0] ind_ch, ans_ch;
  logic [1:0] ans_step;
  logic [31:0] sec_cnt;
  logic sec_tick, inact_exp, ival_exp, ival_active, run_d;
  ssos_pkg::ssos_acc_t access;
  ssos_pkg::ssos_mst_t mstate, after_tab;
  logic [3:0] fld;
  logic [PW-1:0] par_idx;
  logic [N_PARAMS-1:0][31:0] vals;
  logic [7:0] meas_char;
  logic meas_has, tx_free, ld_ind, ld_ans, meas_take, meas_start;
  logic [15:0] tmo_secs;

  wire logic never = (ctrl[`SSOS_CTRL_TMO_MSB:`SSOS_CTRL_TMO_LSB] == `SSOS_TMO_NEVER);
  wire logic label = ctrl[`SSOS_CTRL_LABEL];
  wire logic run = ctrl[`SSOS_CTRL_RUN];
  wire logic cmd_ok = cmd_valid_in && awake;
  wire logic is_cmt = (rx_data_in == `SSOS_CH_SLASH) || (rx_data_in == `SSOS_CH_SEMI);
  wire logic par_end = (par_idx == PW'(N_PARAMS));

  function automatic logic [7:0] hex_char(input logic [3:0] nib);
    hex_char = (nib < 4'ha) ? (`SSOS_CH_ZERO + {4'h0, nib}) : (`SSOS_CH_HEXA + {4'h0, nib});
  endfunction

  function automatic logic [7:0] key_char(input logic [3:0] i);
    logic [87:0] key;
    key = "MEASUREMENT";
    key_char = key[8 * (4'ha - i) +: 8];
  endfunction

  // Timeout code to seconds; never-sleep uses the access revert period.
  always_comb begin
    case (ctrl[`SSOS_CTRL_TMO_MSB:`SSOS_CTRL_TMO_LSB])
      3'h0: tmo_secs = `SSOS_TMO_10S;
      3'h1: tmo_secs = `SSOS_TMO_20S;
      3'h2: tmo_secs = `SSOS_TMO_30S;
      3'h3: tmo_secs = `SSOS_TMO_1M;
      3'h4: tmo_secs = `SSOS_TMO_2M;
      3'h5: tmo_secs = `SSOS_TMO_5M;
      3'h6: tmo_secs = `SSOS_TMO_10M;
      default: tmo_secs = `SSOS_REVERT_S; // RULE18
    endcase
  end

  // Software registers; start and stop commands also steer the run bit.
  always_ff @(posedge clk_sys_in or posedge reset_in) begin
    if (reset_in) begin
      ctrl <= `SSOS_CTRL_RST;
      period <= `SSOS_PERIOD_RST;
      enable <= N_PARAMS'(`SSOS_ENABLE_RST);
      ident <= `SSOS_IDENT_RST;
    end else begin
      if (wr_in) begin
        if (addr_in == `SSOS_REG_CTRL) begin
          ctrl <= wdata_in[4:0];
        end else if (addr_in == `SSOS_REG_PERIOD) begin
          period <= wdata_in[15:0];
        end else if (addr_in == `SSOS_REG_ENABLE) begin
          enable <= wdata_in[N_PARAMS-1:0];
        end else if (addr_in == `SSOS_REG_IDENT) begin
          ident <= wdata_in;
        end
      end
      if (cmd_ok && cmd_in.op == ssos_pkg::SSOS_OP_START) begin
        ctrl[`SSOS_CTRL_RUN] <= 1'b1;
      end else if (cmd_ok && cmd_in.op == ssos_pkg::SSOS_OP_STOP) begin
        ctrl[`SSOS_CTRL_RUN] <= 1'b0;
      end
    end
  end

  // Read data stand one cycle after the strobe; unmapped addresses read zero.
  always_ff @(posedge clk_sys_in or posedge reset_in) begin
    if (reset_in) begin
      rdata_out <= 32'h0;
    end else if (rd_in) begin
      if (addr_in == `SSOS_REG_CTRL) begin
        rdata_out <= {27'h0, ctrl};
      end else if (addr_in == `SSOS_REG_PERIOD) begin
        rdata_out <= {16'h0, period};
      end else if (addr_in == `SSOS_REG_ENABLE) begin
        rdata_out <= 32'(enable);
      end else if (addr_in == `SSOS_REG_IDENT) begin
        rdata_out <= ident;
      end else if (addr_in == `SSOS_REG_STATUS) begin
        rdata_out <= {27'h0, run, (mstate != ssos_pkg::SSOS_M_IDLE), access, awake};
      end else begin
        rdata_out <= 32'h0;
      end
    end else begin
      rdata_out <= 32'h0;
    end
  end

  // One-second time base shared by both timers.
  always_ff @(posedge clk_sys_in or posedge reset_in) begin
    if (reset_in) begin
      sec_cnt <= 32'h0;
      sec_tick <= 1'b0;
    end else begin
      sec_tick <= (sec_cnt == 32'(SEC_CYCLES - 1));
      sec_cnt <= (sec_cnt == 32'(SEC_CYCLES - 1)) ? 32'h0 : sec_cnt + 32'h1;
    end
  end

  // Inactivity timer restarts on every received character.
  ssos_sec_timer #(.W(16)) u_inact (
    .clk_sys_in(clk_sys_in),
    .reset_in(reset_in),
    .tick_in(sec_tick),
    .load_in(rx_valid_in), // RULE10
    .stop_in(1'b0),
    .value_in(tmo_secs),
    .expire_out(inact_exp),
    .active_out()
  );

  // Interval timer starts when running begins and reloads on each expiry.
  always_ff @(posedge clk_sys_in or posedge reset_in) begin
    if (reset_in) begin
      run_d <= 1'b0;
    end else begin
      run_d <= run;
    end
  end

  ssos_sec_timer #(.W(16)) u_ival (
    .clk_sys_in(clk_sys_in),
    .reset_in(reset_in),
    .tick_in(sec_tick),
    .load_in(run && (!run_d || ival_exp)), // RULE19
    .stop_in(!run),
    .value_in(period),
    .expire_out(ival_exp),
    .active_out(ival_active)
  );

  // Sleep state; never-sleep overrides everything else.
  always_ff @(posedge clk_sys_in or posedge reset_in) begin
    if (reset_in) begin
      awake <= 1'b0; // RULE8
    end else if (never) begin
      awake <= 1'b1; // RULE13
    end else if (cmd_ok && cmd_in.op == ssos_pkg::SSOS_OP_RESET) begin
      awake <= 1'b0; // RULE8
    end else if (inact_exp) begin
      awake <= 1'b0; // RULE10
    end else if (rx_valid_in && !awake) begin
      awake <= 1'b1; // RULE9
    end
  end

  // Indicators; a new event wins over the clear by the transmitter.
  always_ff @(posedge clk_sys_in or posedge reset_in) begin
    if (reset_in) begin
      ind_pend <= 1'b0;
      ind_ch <= `SSOS_CH_EXCL;
    end else if (!never && rx_valid_in && !awake) begin
      ind_pend <= 1'b1;
      ind_ch <= `SSOS_CH_EXCL; // RULE12
    end else if (!never && inact_exp && awake) begin
      ind_pend <= 1'b1;
      ind_ch <= `SSOS_CH_PCT; // RULE11
    end else if (ld_ind) begin
      ind_pend <= 1'b0;
    end
  end

  // Access level follows the key command and reverts on inactivity.
  always_ff @(posedge clk_sys_in or posedge reset_in) begin
    if (reset_in) begin
      access <= ssos_pkg::SSOS_ACC_DEF;
    end else if (cmd_ok && cmd_in.op == ssos_pkg::SSOS_OP_PASSKEY) begin
      if (cmd_in.value == `SSOS_KEY_HIGH) begin
        access <= ssos_pkg::SSOS_ACC_HIGH; // RULE15
      end else if (cmd_in.value == `SSOS_KEY_LOW) begin
        access <= ssos_pkg::SSOS_ACC_LOW;
      end else begin
        access <= ssos_pkg::SSOS_ACC_DEF;
      end
    end else if (inact_exp) begin
      access <= ssos_pkg::SSOS_ACC_DEF; // RULE18
    end
  end

  // Comment filter; the waking character is swallowed so it cannot corrupt a line.
  always_ff @(posedge clk_sys_in or posedge reset_in) begin
    if (reset_in) begin
      at_line_start <= 1'b1;
      in_comment <= 1'b0;
      line_valid_out <= 1'b0;
      line_data_out <= 8'h0;
    end else begin
      line_valid_out <= 1'b0;
      if (rx_valid_in && awake) begin
        line_data_out <= rx_data_in;
        line_valid_out <= !(in_comment || (at_line_start && is_cmt)); // RULE7
        at_line_start <= (rx_data_in == `SSOS_CH_LF); // RULE17
        if (rx_data_in == `SSOS_CH_LF) begin
          in_comment <= 1'b0;
        end else if (at_line_start && is_cmt) begin
          in_comment <= 1'b1; // RULE7
        end
      end
    end
  end

  // Command answers: hash or asterisk, then carriage return and line feed.
  always_ff @(posedge clk_sys_in or posedge reset_in) begin
    if (reset_in) begin
      ans_step <= 2'h0;
      ans_ch <= `SSOS_CH_HASH;
    end else if (cmd_ok && cmd_in.op != ssos_pkg::SSOS_OP_SAMPLE) begin
      ans_step <= 2'h1;
      if (cmd_in.op == ssos_pkg::SSOS_OP_ERR) begin
        ans_ch <= `SSOS_CH_STAR; // RULE16
      end else if (cmd_in.op == ssos_pkg::SSOS_OP_PASSKEY &&
                   cmd_in.value != `SSOS_KEY_HIGH && cmd_in.value != `SSOS_KEY_LOW) begin
        ans_ch <= `SSOS_CH_STAR;
      end else begin
        ans_ch <= `SSOS_CH_HASH; // RULE16
      end
    end else if (ld_ans) begin
      ans_step <= ans_step + 2'h1;
    end
  end

  // A sample request waits while another string is going out.
  always_ff @(posedge clk_sys_in or posedge reset_in) begin
    if (reset_in) begin
      sample_pend <= 1'b0;
    end else if ((cmd_ok && cmd_in.op == ssos_pkg::SSOS_OP_SAMPLE) || ival_exp) begin
      sample_pend <= 1'b1; // RULE1
    end else if (meas_start) begin
      sample_pend <= 1'b0;
    end
  end

  assign meas_start = (mstate == ssos_pkg::SSOS_M_IDLE) && sample_pend && !ind_pend &&
                      (ans_step == 2'h0);

  // Character of the current output field.
  always_comb begin
    meas_has = 1'b1;
    case (mstate)
      ssos_pkg::SSOS_M_KEY: meas_char = key_char(fld);
      ssos_pkg::SSOS_M_PROD: meas_char = hex_char(ident[4 * (3 - fld) +: 4]);
      ssos_pkg::SSOS_M_SER: meas_char = hex_char(ident[16 + 4 * (3 - fld) +: 4]);
      ssos_pkg::SSOS_M_NAME: meas_char = (fld == 4'h0) ? `SSOS_CH_P :
                                         (`SSOS_CH_ZERO + 8'(par_idx));
      ssos_pkg::SSOS_M_VAL: meas_char = hex_char(vals[par_idx[PW-2:0]][4 * (7 - fld) +: 4]);
      ssos_pkg::SSOS_M_TAB: meas_char = `SSOS_CH_TAB; // RULE5
      ssos_pkg::SSOS_M_CR: meas_char = `SSOS_CH_CR; // RULE6
      ssos_pkg::SSOS_M_LF: meas_char = `SSOS_CH_LF; // RULE6
      default: begin
        meas_char = 8'h0;
        meas_has = 1'b0;
      end
    endcase
  end

  // Transmit arbitration; indicators and answers never split a string.
  assign tx_free = !tx_valid_out || tx_ready_in;
  assign ld_ind = tx_free && ind_pend && (mstate == ssos_pkg::SSOS_M_IDLE) && (ans_step == 2'h0);
  assign ld_ans = tx_free && !ld_ind && (ans_step != 2'h0) && (mstate == ssos_pkg::SSOS_M_IDLE);
  assign meas_take = tx_free && !ld_ind && !ld_ans && meas_has;

  always_ff @(posedge clk_sys_in or posedge reset_in) begin
    if (reset_in) begin
      tx_valid_out <= 1'b0;
      tx_data_out <= 8'h0;
    end else if (tx_free) begin
      tx_valid_out <= ld_ind || ld_ans || meas_take;
      if (ld_ind) begin
        tx_data_out <= ind_ch; // RULE14
      end else if (ld_ans) begin
        tx_data_out <= (ans_step == 2'h1) ? ans_ch :
                       (ans_step == 2'h2) ? `SSOS_CH_CR : `SSOS_CH_LF; // RULE16
      end else if (meas_take) begin
        tx_data_out <= meas_char;
      end
    end
  end

  // Output string sequencer.
  always_ff @(posedge clk_sys_in or posedge reset_in) begin
    if (reset_in) begin
      mstate <= ssos_pkg::SSOS_M_IDLE;
      after_tab <= ssos_pkg::SSOS_M_IDLE;
      fld <= 4'h0;
      par_idx <= '0;
      vals <= '0;
      sample_start_out <= 1'b0;
    end else begin
      sample_start_out <= meas_start;
      case (mstate)
        ssos_pkg::SSOS_M_IDLE: begin
          if (meas_start) begin
            vals <= param_value_in;
            fld <= 4'h0;
            par_idx <= '0;
            mstate <= label ? ssos_pkg::SSOS_M_KEY : ssos_pkg::SSOS_M_PROD; // RULE3 RULE4
          end
        end
        ssos_pkg::SSOS_M_SCAN: begin
          fld <= 4'h0;
          if (par_end) begin
            mstate <= ssos_pkg::SSOS_M_CR;
          end else if (enable[par_idx[PW-2:0]]) begin
            mstate <= label ? ssos_pkg::SSOS_M_NAME : ssos_pkg::SSOS_M_VAL; // RULE4
          end else begin
            par_idx <= par_idx + PW'(1); // RULE2
          end
        end
        default: begin
          if (meas_take) begin
            fld <= fld + 4'h1;
            case (mstate)
              ssos_pkg::SSOS_M_KEY: if (fld == `SSOS_KEY_LAST) begin
                mstate <= ssos_pkg::SSOS_M_TAB;
                after_tab <= ssos_pkg::SSOS_M_PROD;
              end
              ssos_pkg::SSOS_M_PROD: if (fld == `SSOS_ID_LAST) begin
                mstate <= ssos_pkg::SSOS_M_TAB;
                after_tab <= ssos_pkg::SSOS_M_SER;
              end
              ssos_pkg::SSOS_M_SER: if (fld == `SSOS_ID_LAST) begin
                mstate <= ssos_pkg::SSOS_M_TAB;
                after_tab <= ssos_pkg::SSOS_M_SCAN;
              end
              ssos_pkg::SSOS_M_NAME: if (fld == `SSOS_NAME_LAST) begin
                mstate <= ssos_pkg::SSOS_M_TAB;
                after_tab <= ssos_pkg::SSOS_M_VAL;
              end
              ssos_pkg::SSOS_M_VAL: if (fld == `SSOS_VAL_LAST) begin
                mstate <= ssos_pkg::SSOS_M_TAB;
                after_tab <= ssos_pkg::SSOS_M_SCAN;
                par_idx <= par_idx + PW'(1);
              end
              ssos_pkg::SSOS_M_TAB: begin
                mstate <= after_tab; // RULE5
                fld <= 4'h0;
              end
              ssos_pkg::SSOS_M_CR: mstate <= ssos_pkg::SSOS_M_LF; // RULE6
              default: mstate <= ssos_pkg::SSOS_M_IDLE;
            endcase
          end
        end
      endcase
    end
  end

  // Checks on the behaviour above.
  // The line feed may leave in the very next cycle, so both halves are judged together.
  sequence s_crlf;
    (tx_data_out == `SSOS_CH_CR) && (mstate == ssos_pkg::SSOS_M_LF);
  endsequence

  AST_SAMPLE_GO: assert property (@(posedge clk_sys_in) disable iff (reset_in) // RULE1
    meas_start |=> (mstate != ssos_pkg::SSOS_M_IDLE) && sample_start_out)
    else $error("sample request did not start a string");
  AST_SKIP_OFF: assert property (@(posedge clk_sys_in) disable iff (reset_in) // RULE2
    (mstate == ssos_pkg::SSOS_M_SCAN) && !par_end && !enable[par_idx[PW-2:0]]
    |=> (mstate == ssos_pkg::SSOS_M_SCAN) && (par_idx == $past(par_idx) + PW'(1)))
    else $error("disabled parameter not skipped");
  AST_LABEL_ON: assert property (@(posedge clk_sys_in) disable iff (reset_in) // RULE3
    meas_start && label |=> (mstate == ssos_pkg::SSOS_M_KEY) && (fld == 4'h0))
    else $error("labelled string did not start with keyword");
  AST_LABEL_OFF: assert property (@(posedge clk_sys_in) disable iff (reset_in) // RULE4
    meas_start && !label |=> (mstate == ssos_pkg::SSOS_M_PROD))
    else $error("unlabelled string did not start with product number");
  AST_TAB_SEP: assert property (@(posedge clk_sys_in) disable iff (reset_in) // RULE5
    meas_take && (mstate == ssos_pkg::SSOS_M_TAB) |=> tx_valid_out && (tx_data_out == `SSOS_CH_TAB))
    else $error("field separator was not a tab");
  AST_END_CRLF: assert property (@(posedge clk_sys_in) disable iff (reset_in) // RULE6
    meas_take && (mstate == ssos_pkg::SSOS_M_CR) |=> s_crlf)
    else $error("string end was not carriage return then line feed");
  AST_COMMENT: assert property (@(posedge clk_sys_in) disable iff (reset_in) // RULE7
    rx_valid_in && awake && at_line_start && is_cmt |=> !line_valid_out && in_comment)
    else $error("comment character was forwarded");
  AST_WAKE: assert property (@(posedge clk_sys_in) disable iff (reset_in) // RULE12
    rx_valid_in && !awake && !never |=> awake && ind_pend && (ind_ch == `SSOS_CH_EXCL))
    else $error("wake did not queue ready indicator");
  AST_SLEEP: assert property (@(posedge clk_sys_in) disable iff (reset_in) // RULE11
    inact_exp && awake && !never |=> !awake && ind_pend && (ind_ch == `SSOS_CH_PCT))
    else $error("timeout did not sleep with percent indicator");
  AST_NEVER: assert property (@(posedge clk_sys_in) disable iff (reset_in) // RULE13
    never |=> awake)
    else $error("never-sleep setting left interface asleep");
  AST_ANSWER: assert property (@(posedge clk_sys_in) disable iff (reset_in) // RULE16
    cmd_ok && (cmd_in.op == ssos_pkg::SSOS_OP_OK) |=> (ans_step == 2'h1) && (ans_ch == `SSOS_CH_HASH))
    else $error("valid command not answered with hash");
  AST_KEY_HIGH: assert property (@(posedge clk_sys_in) disable iff (reset_in) // RULE15
    cmd_ok && (cmd_in.op == ssos_pkg::SSOS_OP_PASSKEY) && (cmd_in.value == `SSOS_KEY_HIGH)
    |=> (access == ssos_pkg::SSOS_ACC_HIGH) && (ans_ch == `SSOS_CH_HASH))
    else $error("high key not accepted");
  AST_REVERT: assert property (@(posedge clk_sys_in) disable iff (reset_in) // RULE18
    inact_exp && !(cmd_ok && cmd_in.op == ssos_pkg::SSOS_OP_PASSKEY)
    |=> (access == ssos_pkg::SSOS_ACC_DEF))
    else $error("access level did not revert");
  AST_RELOAD: assert property (@(posedge clk_sys_in) disable iff (reset_in) // RULE19
    ival_exp && run && $past(run) |=> ival_active)
    else $error("interval timer did not reload");

endmodule
`default_nettype wire

/* File: bench/ssos_host_model.sv */
`timescale 1ns/1ps
`default_nettype none
// Host terminal at the far end of the serial link.
module ssos_host_model (
  // Clock and reset
  input wire logic clk_sys_in,
  input wire logic reset_in,
  // Characters to and from the sensor
  output logic rx_valid_out,
  output logic [7:0] rx_data_out,
  input wire logic tx_valid_in,
  input wire logic [7:0] tx_data_in,
  output logic tx_ready_out
);
  string got = "";
  bit slow = 1'b0;
  initial begin
    rx_valid_out = 1'b0;
    rx_data_out = 8'h00;
    tx_ready_out = 1'b0;
  end
  // A slow host takes a character only every other cycle, so the sender must wait.
  always @(posedge clk_sys_in) begin
    if (tx_valid_in && tx_ready_out) got = $sformatf("%s%c", got, tx_data_in);
    tx_ready_out <= reset_in ? 1'b0 : (slow ? ~tx_ready_out : 1'b1);
  end
  // One character a pulse; the idle data are inverted so that stale values never match.
  task automatic send(input logic [7:0] c);
    @(posedge clk_sys_in);
    rx_valid_out <= 1'b1;
    rx_data_out <= c;
    @(posedge clk_sys_in);
    rx_valid_out <= 1'b0;
    rx_data_out <= ~c;
  endtask
endmodule
`default_nettype wire

/* File: bench/ssos_top_test.sv */
`timescale 1ns/1ps
`default_nettype none
// Self-checking bench: one clock of 25 ns, a short second of 20 cycles.
module ssos_top_test;
  logic clk_sys_in = 1'b0;
  logic reset_in;
  logic [7:0] addr;
  logic [31:0] wdata;
  logic [31:0] rdata;
  logic wr, rd, cv;
  logic rxv, txv, txr, lv, ss;
  logic [7:0] rxd, txd, ld;
  ssos_pkg::ssos_cmd_t cq;
  logic [1:0][31:0] pv;
  int bad_count = 0;
  int compares = 0;
  int cyc = 0;
  int lines = 0;
  int starts = 0;
  always #12.5 clk_sys_in = ~clk_sys_in;
  ssos_top #(.N_PARAMS(2), .SEC_CYCLES(20)) u_dut (.clk_sys_in(clk_sys_in),
    .reset_in(reset_in), .addr_in(addr), .wdata_in(wdata), .wr_in(wr), .rd_in(rd),
    .rdata_out(rdata), .rx_valid_in(rxv), .rx_data_in(rxd), .tx_valid_out(txv),
    .tx_data_out(txd), .tx_ready_in(txr), .line_valid_out(lv), .line_data_out(ld),
    .cmd_valid_in(cv), .cmd_in(cq), .sample_start_out(ss), .param_value_in(pv));
  ssos_host_model u_host (.clk_sys_in(clk_sys_in), .reset_in(reset_in),
    .rx_valid_out(rxv), .rx_data_out(rxd), .tx_valid_in(txv), .tx_data_in(txd),
    .tx_ready_out(txr));
  // Counts forwarded characters and string starts; the ceiling cuts a hang short.
  always @(posedge clk_sys_in) begin
    cyc++;
    if (lv === 1'b1) lines++;
    if (ss === 1'b1) starts++;
    if (cyc == 20000) begin
      bad_count++;
      print_verdict();
    end
  end
  task automatic chk(input logic [31:0] g, input logic [31:0] e);
    compares++;
    if (g !== e) begin
      bad_count++;
      $display("[ERR] %0t got %h exp %h", $time, g, e);
    end
  endtask
  // Compares the whole text received since the last check, then clears it.
  task automatic chks(input string e);
    chk(32'(u_host.got.len()), 32'(e.len()));
    for (int i = 0; i < e.len(); i++) chk(32'(u_host.got[i]), 32'(e[i]));
    u_host.got = "";
  endtask
  // Waits for n characters, then a few quiet cycles so that trailing extras show.
  task automatic wait_n(input int n, input int lim);
    for (int i = 0; i < lim && u_host.got.len() < n; i++) @(posedge clk_sys_in);
    repeat (8) @(posedge clk_sys_in);
  endtask
  task automatic wr_reg(input logic [7:0] a, input logic [31:0] d);
    @(posedge clk_sys_in);
    addr <= a;
    wdata <= d;
    wr <= 1'b1;
    @(posedge clk_sys_in);
    wr <= 1'b0;
  endtask
  task automatic rd_chk(input logic [7:0] a, input logic [31:0] e);
    @(posedge clk_sys_in);
    addr <= a;
    rd <= 1'b1;
    @(posedge clk_sys_in);
    rd <= 1'b0;
    #1 chk(rdata, e);
  endtask
  task automatic cmd(input ssos_pkg::ssos_op_t op, input logic [15:0] v);
    @(posedge clk_sys_in);
    cv <= 1'b1;
    cq <= '{op, v};
    @(posedge clk_sys_in);
    cv <= 1'b0;
  endtask
  task automatic t_wake;
    rd_chk(8'h00, 32'h07);
    rd_chk(8'h10, 32'h0);
    u_host.send(8'h0d);
    wait_n(1, 40);
    chks("!");
    rd_chk(8'h10, 32'h1);
  endtask
  task automatic t_comment;
    int l0;
    l0 = lines;
    u_host.send(8'h2f);
    u_host.send(8'h78);
    u_host.send(8'h0a);
    repeat (4) @(posedge clk_sys_in);
    chk(32'(lines), 32'(l0));
    u_host.send(8'h61);
    repeat (4) @(posedge clk_sys_in);
    chk(32'(lines), 32'(l0 + 1));
    chk(32'(ld), 32'h61);
    chks("");
  endtask
  task automatic t_key;
    cmd(ssos_pkg::SSOS_OP_PASSKEY, 16'h0007);
    wait_n(3, 20);
    chks("*\r\n");
    cmd(ssos_pkg::SSOS_OP_ERR, 16'h0);
    wait_n(3, 20);
    chks("*\r\n");
    cmd(ssos_pkg::SSOS_OP_OK, 16'h0);
    wait_n(3, 20);
    chks("#\r\n");
    cmd(ssos_pkg::SSOS_OP_PASSKEY, 16'h03e8);
    wait_n(3, 20);
    chks("#\r\n");
    rd_chk(8'h10, 32'h5);
  endtask
  task automatic t_label;
    wr_reg(8'h08, 32'h2);
    u_host.slow = 1'b1;
    cmd(ssos_pkg::SSOS_OP_SAMPLE, 16'h0);
    wait_n(36, 200);
    u_host.slow = 1'b0;
    chks("MEASUREMENT\t0001\t0001\tP1\t1234ABCD\t\r\n");
  endtask
  task automatic t_plain;
    wr_reg(8'h00, 32'h0);
    wr_reg(8'h08, 32'h3);
    u_host.send(8'h0d);
    u_host.send(8'h0a);
    cmd(ssos_pkg::SSOS_OP_SAMPLE, 16'h0);
    wait_n(30, 100);
    chks("0001\t0001\t1111AAAA\t1234ABCD\t\r\n");
  endtask
  task automatic t_sleep;
    wait_n(1, 260);
    chks("%");
    rd_chk(8'h10, 32'h0);
  endtask
  task automatic t_run;
    int s0;
    wr_reg(8'h04, 32'h3);
    wr_reg(8'h00, 32'h0e);
    cmd(ssos_pkg::SSOS_OP_START, 16'h0);
    s0 = starts;
    rd_chk(8'h00, 32'h1e);
    repeat (148) @(posedge clk_sys_in);
    chk(32'(starts - s0), 32'h2);
    cmd(ssos_pkg::SSOS_OP_STOP, 16'h0);
    repeat (60) @(posedge clk_sys_in);
    s0 = starts;
    repeat (100) @(posedge clk_sys_in);
    chk(32'(starts - s0), 32'h0);
    rd_chk(8'h10, 32'h1);
    wr_reg(8'h00, 32'h0);
    u_host.got = "";
    cmd(ssos_pkg::SSOS_OP_RESET, 16'h0);
    wait_n(3, 20);
    chks("#\r\n");
    rd_chk(8'h10, 32'h0);
  endtask
  task automatic print_verdict;
    $display("Comparisons %0d, mismatches %0d", compares, bad_count);
    if (bad_count == 0 && compares > 0) $display("Regression OK");
    else $display("Regression broken");
    $finish;
  endtask
  initial begin
    reset_in = 1'b1;
    addr = 8'h00;
    wdata = 32'h0;
    wr = 1'b0;
    rd = 1'b0;
    cv = 1'b0;
    cq = '0;
    pv = {32'h1234abcd, 32'h1111aaaa};
    repeat (3) @(posedge clk_sys_in);
    reset_in <= 1'b0;
    t_wake();
    t_comment();
    t_key();
    t_label();
    t_plain();
    t_sleep();
    t_run();
    print_verdict();
  end
endmodule
`default_nettype wire
